// File: rtl/dfsel_pkg.sv
// package: constants and types for the damping filter selection block
package dfsel_pkg;
  // setting widths
  localparam int unsigned FREQ_W  = 12;
  localparam int unsigned DEPTH_W = 10;
  localparam int unsigned CNT_W   = 7;
  localparam int unsigned AMP_W   = 28;
  localparam int unsigned NFILT   = 4;
  // frequency limits in 0.1 Hz steps
  localparam logic [11:0] FREQ_MAX      = 12'hBB8;  // 3000
  localparam logic [11:0] FREQ_OFF_MAX  = 12'h004;  // 0..4 disables
  localparam logic [11:0] SETUP_MAX     = 12'h5DC;  // 1500
  // depth and width limits
  localparam logic [9:0]  DEPTH_MAX     = 10'h3E8;  // 1000
  localparam logic [9:0]  WIDTH_MIN     = 10'h00A;  // 10
  localparam logic [9:0]  WIDTH_SUB     = 10'h064;  // 100
  localparam logic [9:0]  WIDTH_MAX     = 10'h3E8;  // 1000
  // detection settings limits
  localparam logic [6:0]  VCNT_MAX      = 7'h64;    // 100
  localparam logic [27:0] AMP_MAX       = 28'h8000000;
  // amplitude used when the host leaves the threshold at zero
  localparam logic [27:0] AMP_AUTO      = 28'h0000100;
  // reset values of the applied settings
  localparam logic [11:0] FREQ_RST      = 12'h000;
  localparam logic [9:0]  WIDTH_RST     = 10'h000;
  localparam logic [2:0]  METHOD_RST    = 3'h0;

  // switching methods
  typedef enum logic [2:0] {
    DFSEL_M_STATIC = 3'b000,
    DFSEL_M_RSV1   = 3'b001,
    DFSEL_M_RSV2   = 3'b010,
    DFSEL_M_DIR    = 3'b011,
    DFSEL_M_MODE4  = 3'b100,
    DFSEL_M_RSV5   = 3'b101,
    DFSEL_M_MODE6  = 3'b110,
    DFSEL_M_MODE7  = 3'b111
  } dfsel_method_t;

  // control modes
  typedef enum logic [1:0] {
    DFSEL_CM_POS  = 2'b00,
    DFSEL_CM_VEL  = 2'b01,
    DFSEL_CM_TRQ  = 2'b10,
    DFSEL_CM_FULL = 2'b11
  } dfsel_mode_t;

  // apply sequencer states
  typedef enum logic [1:0] {
    DFSEL_S_IDLE    = 2'b00,
    DFSEL_S_PENDING = 2'b01,
    DFSEL_S_APPLY   = 2'b10
  } dfsel_state_t;
endpackage

// File: rtl/dfsel_clamp.sv
// one filter channel: clamps frequency, setup, depth and width
`timescale 1ns/1ps
module dfsel_clamp (
  input  wire logic [11:0] freq_in,    // raw frequency, 0.1 Hz
  input  wire logic [11:0] setup_in,   // raw filter setup
  input  wire logic [9:0]  depth_in,   // raw depth
  input  wire logic [9:0]  width_in,   // raw width
  output logic      [11:0] freq_out,   // clamped frequency
  output logic      [11:0] setup_out,  // effective setup
  output logic      [9:0]  depth_out,  // clamped depth
  output logic      [9:0]  width_out,  // effective width
  output logic             freq_ok     // frequency in usable range
);
  logic [11:0] cap;

  // frequency clamp, setup cap, depth and width substitution
  always_comb begin
    freq_out = (freq_in > dfsel_pkg::FREQ_MAX) ? dfsel_pkg::FREQ_MAX
                                               : freq_in;
    freq_ok  = (freq_out > dfsel_pkg::FREQ_OFF_MAX);
    // cap is min(freq, 3000 - freq); never underflows after clamp
    cap = dfsel_pkg::FREQ_MAX - freq_out;
    if (freq_out < cap) begin
      cap = freq_out;
    end
    setup_out = (setup_in > dfsel_pkg::SETUP_MAX) ? dfsel_pkg::SETUP_MAX
                                                  : setup_in;
    if (setup_out > cap) begin
      setup_out = cap;
    end
    depth_out = (depth_in > dfsel_pkg::DEPTH_MAX) ? dfsel_pkg::DEPTH_MAX
                                                  : depth_in;
    if (width_in < dfsel_pkg::WIDTH_MIN) begin
      width_out = dfsel_pkg::WIDTH_SUB;
    end else if (width_in > dfsel_pkg::WIDTH_MAX) begin
      width_out = dfsel_pkg::WIDTH_MAX;
    end else begin
      width_out = width_in;
    end
  end
endmodule // dfsel_clamp

// File: rtl/dfsel_top.sv
// damping filter selection: setting clamp, enable decode, apply timing
// Behaviour
// - fourth frequency 0..3000, 0..4 disables
// - setup capped by min(freq, 3000-freq)
// - width 0..9 replaced by 100
// - depth 0..1000, zero deepest
// - hold detection start vibration count 0..100
// - hold amplitude threshold, zero picks internal
// - method 3 picks filters by direction
// - method 4 two-dof enables both model dampers
// - method 6 two-dof picks model damper by direction
// - plain position: 4 gives 1-3, 5/6 give 1-2
// - full-closed methods 4-6 give filters 1-2
// - method 7 gives 1-3 in full-closed or two-dof, else 1-2
// - method range 0..7 governs all enables
// - first three frequencies behave like fourth
// - apply changes on command rise during in-position
// - damping only in position or full-closed
`timescale 1ns/1ps
module dfsel_top (
  input  wire logic        core_clk,         // 100 MHz control clock
  input  wire logic        rst,              // async reset, active high
  input  wire logic        clk_en,           // freezes all state when low
  input  wire logic [2:0]  damping_switch_method, // switching method
  input  wire logic [1:0]  control_mode,     // 0 pos,1 vel,2 trq,3 full
  input  wire logic        two_dof_en,       // two-dof control enabled
  input  wire logic        cmd_negative,     // command direction negative
  input  wire logic        cmd_nonzero,      // pre-filter command nonzero
  input  wire logic        in_position,      // in-position output
  input  wire logic [47:0] damping_frequency,  // four 12-bit, filter 1 low
  input  wire logic [47:0] filter_setup,       // four 12-bit setups
  input  wire logic [39:0] damping_depth,      // four 10-bit depths
  input  wire logic [39:0] damping_width,      // four 10-bit widths
  input  wire logic [6:0]  detect_start_vibration_count, // 0..100
  input  wire logic [27:0] detect_vibration_amplitude,   // command units
  output logic      [3:0]  filter_active,    // per-filter active
  output logic      [1:0]  model_damp_en,    // model damping 1 and 2
  output logic             damping_on,       // damping control running
  output logic      [47:0] applied_frequency, // applied clamped freqs
  output logic      [47:0] applied_setup,    // applied effective setups
  output logic      [39:0] applied_depth,    // applied depths
  output logic      [39:0] applied_width,    // applied widths
  output logic      [6:0]  vib_count_eff,    // held vibration count
  output logic      [27:0] vib_amp_eff,      // held amplitude threshold
  output logic             amp_auto,         // threshold chosen inside
  output logic             apply_pending,    // new settings waiting
  output logic             apply_pulse       // one cycle when applied
);
  // clamped live settings from the channel modules
  logic [47:0] cf;
  logic [47:0] cs;
  logic [39:0] cd;
  logic [39:0] cw;
  logic [3:0]  fok;

  // one clamp per filter; the channels share nothing, so a bad
  // setting on one filter cannot disturb another
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      dfsel_clamp u_clamp (
        .freq_in   (damping_frequency[gi*12 +: 12]),
        .setup_in  (filter_setup[gi*12 +: 12]),
        .depth_in  (damping_depth[gi*10 +: 10]),
        .width_in  (damping_width[gi*10 +: 10]),
        .freq_out  (cf[gi*12 +: 12]),
        .setup_out (cs[gi*12 +: 12]),
        .depth_out (cd[gi*10 +: 10]),
        .width_out (cw[gi*10 +: 10]),
        .freq_ok   (fok[gi])
      );
    end
  endgenerate

  // enable pattern for a method, mode, two-dof flag and direction;
  // returns {model2, model1, f4, f3, f2, f1}
  // refused codes decode to nothing, the safe answer for a bad write
  function automatic logic [5:0] enables(input logic [2:0] m,
                                         input logic [1:0] cm,
                                         input logic       tdof,
                                         input logic       neg);
    logic full;
    full = (cm == dfsel_pkg::DFSEL_CM_FULL);
    enables = 6'h00;
    case (m)
      dfsel_pkg::DFSEL_M_STATIC: enables = 6'h06;
      dfsel_pkg::DFSEL_M_DIR:
        enables = neg ? 6'h0A : 6'h05;
      dfsel_pkg::DFSEL_M_MODE4: begin
        if (full) begin
          enables = 6'h03;
        end else if (tdof) begin
          enables = 6'h30;
        end else begin
          enables = 6'h07;
        end
      end
      dfsel_pkg::DFSEL_M_RSV5: begin
        // reserved with two-dof outside full-closed: nothing is enabled, so a
        // stray write cannot switch on an untried combination
        if (full) begin
          enables = 6'h03;
        end else if (!tdof) begin
          enables = 6'h03;
        end else begin
          enables = 6'h00;
        end
      end
      dfsel_pkg::DFSEL_M_MODE6: begin
        if (full) begin
          enables = 6'h03;
        end else if (tdof) begin
          enables = neg ? 6'h20 : 6'h10;
        end else begin
          enables = 6'h03;
        end
      end
      dfsel_pkg::DFSEL_M_MODE7:
        enables = (full || tdof) ? 6'h07 : 6'h03;
      default: enables = 6'h00;  // codes 1, 2 are refused
    endcase
  endfunction

  // applied state
  logic [2:0]  method_q, method_d;
  logic [47:0] af_q, af_d;
  logic [47:0] as_q, as_d;
  logic [39:0] ad_q, ad_d;
  logic [39:0] aw_q, aw_d;
  logic [3:0]  fok_q, fok_d;
  logic        pend_q, pend_d;
  logic        pulse_q, pulse_d;
  logic        nz_q, nz_d;
  logic        first_q, first_d;
  dfsel_pkg::dfsel_state_t st_q, st_d;

  // detection state, tracked on every enabled edge
  logic [6:0]  vc_q, vc_d;
  logic [27:0] va_q, va_d;
  logic        auto_q, auto_d;

  // decoded enables
  logic [3:0]  fa_q, fa_d;
  logic [1:0]  md_q, md_d;
  logic        on_q, on_d;

  // sequencer helpers and the raw enable word
  logic        changed;
  logic        rise;
  logic        active_mode;
  logic [5:0]  en;

  // apply sequencer: changes wait for a command rise while in position
  // the whole set moves at once so no filter runs half old, half new
  always_comb begin
    changed = (cf != af_q) || (cs != as_q) || (cd != ad_q) ||
              (cw != aw_q) || (damping_switch_method != method_q);
    rise = cmd_nonzero && !nz_q;
    active_mode = (control_mode == dfsel_pkg::DFSEL_CM_POS) ||
                  (control_mode == dfsel_pkg::DFSEL_CM_FULL);
    method_d = method_q;
    af_d = af_q;
    as_d = as_q;
    ad_d = ad_q;
    aw_d = aw_q;
    fok_d = fok_q;
    pulse_d = 1'b0;
    nz_d = cmd_nonzero;
    first_d = 1'b0;
    st_d = st_q;
    case (st_q)
      dfsel_pkg::DFSEL_S_IDLE: begin
        // first settings after reset load at once, so the outputs do
        // not sit on the all-zero reset pattern once the clock runs
        if (first_q) begin
          st_d = dfsel_pkg::DFSEL_S_APPLY;
        end else if (changed && active_mode) begin
          st_d = dfsel_pkg::DFSEL_S_PENDING;
        end
      end
      dfsel_pkg::DFSEL_S_PENDING: begin
        // changes made outside position modes are not taken up; the
        // wait is dropped and rebuilt once the mode comes back
        if (!active_mode) begin
          st_d = dfsel_pkg::DFSEL_S_IDLE;
        end else if (rise && in_position) begin
          st_d = dfsel_pkg::DFSEL_S_APPLY;
        end
      end
      dfsel_pkg::DFSEL_S_APPLY: begin
        method_d = damping_switch_method;
        af_d = cf;
        as_d = cs;
        ad_d = cd;
        aw_d = cw;
        fok_d = fok;
        pulse_d = 1'b1;
        st_d = dfsel_pkg::DFSEL_S_IDLE;
      end
      default: st_d = dfsel_pkg::DFSEL_S_IDLE;
    endcase
    pend_d = (st_d == dfsel_pkg::DFSEL_S_PENDING);
  end

  // detection settings are held directly, clamped to range; they only
  // steer the frequency search, so they need not wait for a move start
  always_comb begin
    vc_d = (detect_start_vibration_count > dfsel_pkg::VCNT_MAX) ?
           dfsel_pkg::VCNT_MAX : detect_start_vibration_count;
    auto_d = (detect_vibration_amplitude == 28'h0000000);
    if (auto_d) begin
      va_d = dfsel_pkg::AMP_AUTO;
    end else if (detect_vibration_amplitude > dfsel_pkg::AMP_MAX) begin
      va_d = dfsel_pkg::AMP_MAX;
    end else begin
      va_d = detect_vibration_amplitude;
    end
  end

  // decode from applied settings; mode and direction are live, so a
  // direction flip shows on the next edge without a new apply
  always_comb begin
    en = enables(method_q, control_mode, two_dof_en, cmd_negative);
    on_d = active_mode;
    fa_d = active_mode ? (en[3:0] & fok_q) : 4'h0;
    // model dampers follow first two frequencies being usable
    md_d = active_mode ? (en[5:4] & fok_q[1:0]) : 2'h0;
  end

  // registers; clk_en low holds everything
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      method_q <= dfsel_pkg::METHOD_RST;
      af_q <= {4{dfsel_pkg::FREQ_RST}};
      as_q <= 48'h000000000000;
      ad_q <= 40'h0000000000;
      aw_q <= {4{dfsel_pkg::WIDTH_RST}};
      fok_q <= 4'h0;
      pend_q <= 1'b0;
      pulse_q <= 1'b0;
      nz_q <= 1'b0;
      first_q <= 1'b1;
      st_q <= dfsel_pkg::DFSEL_S_IDLE;
    end else if (clk_en) begin
      method_q <= method_d;
      af_q <= af_d;
      as_q <= as_d;
      ad_q <= ad_d;
      aw_q <= aw_d;
      fok_q <= fok_d;
      pend_q <= pend_d;
      pulse_q <= pulse_d;
      nz_q <= nz_d;
      first_q <= first_d;
      st_q <= st_d;
    end
  end

  // detection registers; clk_en low holds them as well
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vc_q <= 7'h00;
      va_q <= dfsel_pkg::AMP_AUTO;
      auto_q <= 1'b1;
    end else if (clk_en) begin
      vc_q <= vc_d;
      va_q <= va_d;
      auto_q <= auto_d;
    end
  end

  // decoded enable registers; reset leaves every filter off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fa_q <= 4'h0;
      md_q <= 2'h0;
      on_q <= 1'b0;
    end else if (clk_en) begin
      fa_q <= fa_d;
      md_q <= md_d;
      on_q <= on_d;
    end
  end

  // outputs straight from flops: decoded enables
  assign filter_active = fa_q;
  assign model_damp_en = md_q;
  assign damping_on = on_q;

  // applied settings and sequencer status
  assign applied_frequency = af_q;
  assign applied_setup = as_q;
  assign applied_depth = ad_q;
  assign applied_width = aw_q;
  assign apply_pending = pend_q;
  assign apply_pulse = pulse_q;

  // detection settings
  assign vib_count_eff = vc_q;
  assign vib_amp_eff = va_q;
  assign amp_auto = auto_q;
endmodule // dfsel_top

// File: test/dfsel_top_sva.sv
// checker: timing and range properties of the filter selection block
`timescale 1ns/1ps
module dfsel_top_sva (
  input wire logic        core_clk,          // clock
  input wire logic        rst,               // reset
  input wire logic [1:0]  control_mode,      // mode
  input wire logic        cmd_nonzero,       // command
  input wire logic        in_position,       // settled
  input wire logic [6:0]  detect_start_vibration_count, // count in
  input wire logic [27:0] detect_vibration_amplitude,   // amp in
  input wire logic [3:0]  filter_active,     // enables
  input wire logic        damping_on,        // running
  input wire logic [47:0] applied_frequency, // freqs
  input wire logic [47:0] applied_setup,     // setups
  input wire logic [39:0] applied_width,     // widths
  input wire logic [6:0]  vib_count_eff,     // count out
  input wire logic        amp_auto,          // auto flag
  input wire logic        apply_pulse        // applied
);
  logic boot_q;  // set after the first load
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // the reset-time load needs no command rise, so it is exempted
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) boot_q <= 1'b0;
    else if (apply_pulse) boot_q <= 1'b1;
  end
  pulse_once_a: assert property (apply_pulse |=> !apply_pulse)
    else $error("apply pulse longer than one cycle");
  apply_rise_a: assert property (apply_pulse && boot_q |->
    $past(cmd_nonzero, 2) && !$past(cmd_nonzero, 3) && $past(in_position, 2))
    else $error("settings applied without a command rise");
  freq_range_a: assert property (apply_pulse |->
    applied_frequency[47:36] <= 12'hBB8 && applied_frequency[11:0] <= 12'hBB8)
    else $error("applied frequency above range");
  setup_cap_a: assert property (apply_pulse |->
    applied_setup[47:36] <= applied_frequency[47:36] &&
    {1'b0, applied_setup[47:36]} + {1'b0, applied_frequency[47:36]} <= 13'hBB8)
    else $error("setup above its cap");
  width_sub_a: assert property (apply_pulse |->
    applied_width[39:30] inside {[10'h00A:10'h3E8]})
    else $error("width outside usable range");
  count_track_a: assert property (1'b1 |=> vib_count_eff ==
    ($past(detect_start_vibration_count) > 7'h64 ? 7'h64 :
     $past(detect_start_vibration_count)))
    else $error("vibration count not held");
  amp_track_a: assert property (1'b1 |=>
    amp_auto == ($past(detect_vibration_amplitude) == 28'h0))
    else $error("auto threshold flag wrong");
  mode_gate_a: assert property (1'b1 |=>
    damping_on == ($past(control_mode) inside {2'b00, 2'b11}))
    else $error("damping run state wrong for mode");
  fok_gate_a: assert property (filter_active[3] &&
    $stable(applied_frequency) |-> applied_frequency[47:36] > 12'h004)
    else $error("filter four active while disabled");
endmodule // dfsel_top_sva
bind dfsel_top dfsel_top_sva dfsel_top_sva_inst (.core_clk, .rst,
  .control_mode, .cmd_nonzero, .in_position, .detect_start_vibration_count,
  .detect_vibration_amplitude, .filter_active, .damping_on,
  .applied_frequency, .applied_setup, .applied_width, .vib_count_eff,
  .amp_auto, .apply_pulse);

// File: test/dfsel_host.sv
// host partner: makes a command that starts from zero while settled
`timescale 1ns/1ps
module dfsel_host (
  input  wire logic       core_clk,     // clock
  input  wire logic       rst,          // reset
  input  wire logic       start,        // begin a move
  input  wire logic       neg_req,      // direction wanted
  input  wire logic [1:0] lag,          // extra idle cycles
  output logic            cmd_nonzero,  // command nonzero
  output logic            cmd_negative, // command direction
  output logic            in_position   // settled
);
  int n;
  // two cycles of command; settled drops a cycle after the rise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      n <= 0;
      cmd_nonzero <= 1'b0;
      in_position <= 1'b1;
    end else begin
      n <= n > 0 ? n - 1 : (start ? lag + 3 : 0);
      cmd_nonzero <= n == 1 || n == 2;
      in_position <= !cmd_nonzero;
    end
  end
  assign cmd_negative = neg_req;  // direction is a plain level
endmodule // dfsel_host

// File: test/tb_top.sv
// testbench: reference model of clamps and enable table against design
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
  logic [2:0]  damping_switch_method = 3'h0;
  logic [1:0]  control_mode = 2'h0, lag = 2'h0;
  logic        two_dof_en = 1'b0, start = 1'b0, neg_req = 1'b0;
  logic        cmd_negative, cmd_nonzero, in_position;
  logic [47:0] damping_frequency = {12'h004, 12'h005, 12'hBB8, 12'hFFF};
  logic [47:0] filter_setup = {12'hFFF, 12'h5DC, 12'h5DC, 12'h001};
  logic [39:0] damping_depth = {10'h3FF, 10'h3E8, 10'h000, 10'h001};
  logic [39:0] damping_width = {10'h009, 10'h00A, 10'h3E8, 10'h3FF};
  logic [6:0]  detect_start_vibration_count = 7'h7F, vib_count_eff;
  logic [27:0] detect_vibration_amplitude = 28'h0, vib_amp_eff;
  logic [3:0]  filter_active;
  logic [1:0]  model_damp_en;
  logic        damping_on, amp_auto, apply_pending, apply_pulse;
  logic [47:0] applied_frequency, applied_setup;
  logic [39:0] applied_depth, applied_width;
  int          fails = 0, samples_checked = 0, meth = 0, ef[4];
  int          ml[$] = '{3, 4, 6, 7, 0, 3};  // no codes 1,2,5
  dfsel_top dfsel_top_inst (.core_clk, .rst, .clk_en, .damping_switch_method,
    .control_mode, .two_dof_en, .cmd_negative, .cmd_nonzero, .in_position,
    .damping_frequency, .filter_setup, .damping_depth, .damping_width,
    .detect_start_vibration_count, .detect_vibration_amplitude,
    .filter_active, .model_damp_en, .damping_on, .applied_frequency,
    .applied_setup, .applied_depth, .applied_width, .vib_count_eff,
    .vib_amp_eff, .amp_auto, .apply_pending, .apply_pulse);
  dfsel_host dfsel_host_inst (.core_clk, .rst, .start, .neg_req, .lag,
    .cmd_nonzero, .cmd_negative, .in_position);
  always #5 core_clk = ~core_clk;
  // reference clamps; the setup cap works on the clamped frequency
  function automatic int cf(int f); return f > 3000 ? 3000 : f; endfunction
  function automatic int cs(int s, int f);
    int c;
    c = cf(f) < 3000 - cf(f) ? cf(f) : 3000 - cf(f);
    s = s > 1500 ? 1500 : s;
    return s < c ? s : c;
  endfunction
  // enable table: bits 3..0 filters, bits 5..4 model dampers
  function automatic int en(int m, int cm, bit t, bit g);
    bit p;
    p = cm == 0;
    if (cm == 1 || cm == 2) return 0;
    case (m)
      0: return 6;
      3: return g ? 10 : 5;
      4: return p && t ? 48 : (p ? 7 : 3);
      6: return p && t ? (g ? 32 : 16) : 3;
      7: return p && !t ? 3 : 7;
      default: return 0;
    endcase
  endfunction
  task automatic tick(); @(posedge core_clk); #1; endtask
  task automatic chk(string nm, logic [47:0] s, logic [47:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_apply();
    int a, c;
    a = detect_vibration_amplitude;
    c = detect_start_vibration_count;
    for (int n = 0; n < 4; n++) begin
      ef[n] = cf(damping_frequency[12*n+:12]);
      chk("freq", applied_frequency[12*n+:12], ef[n]);
      chk("setup", applied_setup[12*n+:12],
          cs(filter_setup[12*n+:12], damping_frequency[12*n+:12]));
      a = damping_depth[10*n+:10];
      chk("depth", applied_depth[10*n+:10], a > 1000 ? 1000 : a);
      a = damping_width[10*n+:10];
      chk("width", applied_width[10*n+:10],
          a < 10 ? 100 : (a > 1000 ? 1000 : a));
    end
    a = detect_vibration_amplitude;
    chk("count", vib_count_eff, c > 100 ? 100 : c);
    chk("amp", vib_amp_eff, a == 0 ? int'(dfsel_pkg::AMP_AUTO) :
        (a > 2**27 ? 2**27 : a));
    chk("auto", amp_auto, a == 0);
  endtask
  // every mode, two-dof and direction against the applied method
  task automatic sweep();
    int e, ok;
    for (int k = 0; k < 16; k++) begin
      {control_mode, two_dof_en, neg_req} = k[3:0];
      tick();
      ok = 0;
      for (int n = 0; n < 4; n++) ok |= (ef[n] > 4) << n;
      e = en(meth, control_mode, two_dof_en, neg_req);
      chk("filters", filter_active, e & ok);
      chk("model", model_damp_en, (e >> 4) & ok & 3);
      chk("on", damping_on, control_mode == 0 || control_mode == 3);
    end
    {control_mode, two_dof_en} = 3'h0;
  endtask
  task automatic wait_apply();
    int i;
    for (i = 0; i < 20 && apply_pulse !== 1'b1; i++) tick();
    chk("wait", i < 20, 1);
    chk_apply();
    tick();
    chk("pulse", apply_pulse, 0);
  endtask
  // new random settings stay pending until the host command rises
  task automatic apply(int m);
    damping_switch_method = m[2:0];
    damping_frequency = 48'({$urandom(), $urandom()});
    filter_setup = 48'({$urandom(), $urandom()});
    damping_depth = 40'({$urandom(), $urandom()});
    damping_width = 40'({$urandom(), $urandom()});
    // enable low freezes the sequencer, so the change is not seen yet
    clk_en = 1'b0;
    repeat (2) tick();
    chk("frozen", apply_pending, 0);
    clk_en = 1'b1;
    detect_start_vibration_count = 7'($urandom());
    detect_vibration_amplitude = 28'($urandom());
    lag = 2'($urandom());
    repeat (4) tick();
    chk("early", apply_pulse, 0);
    chk("pending", apply_pending, 1);
    start = 1'b1;
    tick();
    start = 1'b0;
    wait_apply();
    meth = m;
    sweep();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(88147));
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    wait_apply();
    sweep();
    foreach (ml[j]) apply(ml[j]);
    report_and_stop();
  end
  // a hang is cut off well beyond the expected run length
  initial begin
    #50000;
    fails++;
    report_and_stop();
  end
endmodule // tb_top
